// ### asp_cfg.svh
// register offsets, field positions and timing constants of the addressable serial port
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
`define ASP_ADR_RX_STAT 6'h00
`define ASP_ADR_RX_DATA 6'h04
`define ASP_ADR_TX_STAT 6'h08
`define ASP_ADR_BAUD 6'h0c
`define ASP_ADR_TX_DATA 6'h10
`define ASP_ADR_FLAGS 6'h14
`define ASP_ADR_ENABLES 6'h18
`define ASP_ADR_PRIO 6'h1c
`define ASP_RS_PORT_EN 7
`define ASP_RS_NINE 6
`define ASP_RS_SINGLE 5
`define ASP_RS_CONT 4
`define ASP_RS_ADDR 3
`define ASP_RS_FRAMING_ERROR 2
`define ASP_RS_OVERRUN_ERROR 1
`define ASP_RS_NINTH 0
`define ASP_TS_CLK_SRC 7
`define ASP_TS_NINE 6
`define ASP_TS_TX_EN 5
`define ASP_TS_SYNC 4
`define ASP_TS_HIGH_SPEED 2
`define ASP_TS_SHIFT_EMPTY 1
`define ASP_TS_NINTH 0
`define ASP_PF_RX 5
`define ASP_PF_TX 4
`define ASP_RS_WR_MASK 8'hf8
`define ASP_TS_WR_MASK 8'hf5
`define ASP_PF_MASK 8'h30
`define ASP_OVS_LAST 4'hf
`define ASP_OVS_MID 4'h7
`define ASP_PRE_FAST 2'h0
`define ASP_PRE_SLOW 2'h3
`endif

// ### asp_pkg.sv
// types of the addressable serial port
package asp_pkg;
    typedef struct packed {
        logic [5:0] adr;
        logic [31:0] dat;
        logic we;
        logic [3:0] sel;
        logic cyc;
        logic stb;
    } asp_wb_req_t;
    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } asp_wb_rsp_t;
    typedef enum logic [1:0] {
        ASP_RX_IDLE = 2'b00,
        ASP_RX_START = 2'b01,
        ASP_RX_DATA = 2'b10,
        ASP_RX_STOP = 2'b11
    } asp_rx_state_t;
    typedef enum logic [1:0] {
        ASP_TX_IDLE = 2'b00,
        ASP_TX_START = 2'b01,
        ASP_TX_DATA = 2'b10,
        ASP_TX_STOP = 2'b11
    } asp_tx_state_t;
endpackage

// ### asp_remote_node.sv
// remote serial node: sends async frames, captures sync master words
`timescale 1ns/1ps
module asp_remote_node
(
    input wire logic i_clk_sys,
    input wire logic i_sck,
    input wire logic i_sdo,
    input wire logic i_oe,
    output logic o_line
);
    logic sck_d = 1'b0;
    logic [15:0] got = 16'h0;
    int n = 0;
    initial
        o_line = 1'b1;
    // sample on the rising shift clock, the device moves data on the fall
    always @(posedge i_clk_sys)
    begin
        sck_d <= i_sck;
        if (i_oe && i_sck && !sck_d)
        begin
            got <= {i_sdo, got[15:1]};
            n <= n + 1;
        end
    end
    // one idle bit after the stop so frames never touch
    task automatic send(input logic [8:0] w, input int nb, input logic stop, input int clks);
        for (int i = 0; i < nb + 2; i++)
        begin
            o_line <= (i == 0) ? 1'b0 : (i > nb) ? stop : w[i - 1];
            repeat (clks) @(posedge i_clk_sys);
        end
        o_line <= 1'b1;
        repeat (clks) @(posedge i_clk_sys);
    endtask
endmodule

// ### asp_serial_port.sv
// addressable serial port: async receiver, sync master transmitter, wishbone registers
// Function
// R1 - receiver samples line at sixteen times baud
// R2 - async when sync clear and port enabled
// R3 - receive needs continuous enable; nine-bit option
// R4 - word done sets flag; interrupt if enabled
// R5 - status shows ninth bit, errors; data low byte
// R6 - clearing continuous enable clears receive errors
// R7 - software sets nine-bit, address-detect, then enable
// R8 - software reads words to check its address
// R9 - address detect off delivers every word
// R10 - baud set by divisor and high-speed select
// R11 - clock source bit seven gives master clock
// R12 - sync select bit four picks synchronous
// R13 - port enable turns pins to clock, data
// R14 - sync mode is half duplex
// R15 - shifter reloads only after last bit sent
// R16 - buffer to shifter move sets empty flag
// R17 - empty flag not software clearable; write clears
// R18 - transmit enable gates empty flag interrupt
// R19 - shift-empty bit is read-only polled status
// R20 - writing buffer with transmit enabled starts send
// R21 - unimplemented bits read zero
// R22 - async frame: start, eight/nine data, stop
// R23 - least significant bit first
// R24 - baud clock sixteen or sixty-four times bit
// R25 - address detect keeps only ninth-bit-one words
// R26 - sync master data follows generated clock
`timescale 1ns/1ps
`include "asp_cfg.svh"
module asp_serial_port
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire asp_pkg::asp_wb_req_t i_wb,
    output asp_pkg::asp_wb_rsp_t o_wb,
    input wire logic i_rx_pin,
    output logic o_tx_pin,
    output logic o_data_out,
    output logic o_data_oe,
    output logic o_rx_irq,
    output logic o_tx_irq
);
    import asp_pkg::*;

    logic [7:0] rx_stat;
    logic [7:0] tx_stat;
    logic [7:0] baud;
    logic [7:0] tx_buf;
    logic tx_buf_full;
    logic [7:0] rx_buf;
    logic rx_flag;
    logic tx_flag;
    logic [7:0] enables;
    logic [7:0] prio;
    logic ack;
    logic [31:0] rd_dat;
    logic [31:0] rd_q;

    // bus decode
    wire bus_req = i_wb.cyc && i_wb.stb && !ack;
    wire bus_wr = bus_req && i_wb.we && i_wb.sel[0];
    wire bus_rd = bus_req && !i_wb.we;
    wire wr_rs = bus_wr && (i_wb.adr == `ASP_ADR_RX_STAT);
    wire wr_ts = bus_wr && (i_wb.adr == `ASP_ADR_TX_STAT);
    wire wr_baud = bus_wr && (i_wb.adr == `ASP_ADR_BAUD);
    wire wr_txd = bus_wr && (i_wb.adr == `ASP_ADR_TX_DATA);
    wire wr_en = bus_wr && (i_wb.adr == `ASP_ADR_ENABLES);
    wire wr_pr = bus_wr && (i_wb.adr == `ASP_ADR_PRIO);
    wire rd_rxd = bus_rd && (i_wb.adr == `ASP_ADR_RX_DATA);

    wire port_en = rx_stat[`ASP_RS_PORT_EN];
    wire sync_mode = tx_stat[`ASP_TS_SYNC];
    wire async_on = port_en && !sync_mode; // R2
    wire master_on = port_en && sync_mode && tx_stat[`ASP_TS_CLK_SRC]; // R11 R12 R13
    wire cont_en = rx_stat[`ASP_RS_CONT];
    wire nine_rx = rx_stat[`ASP_RS_NINE];
    wire tx_en = tx_stat[`ASP_TS_TX_EN];

    // baud generator: prescale by 4 for x64 so a tick is always x16 of the bit rate
    logic [7:0] brg_cnt;
    logic [1:0] pre_cnt;
    wire brg_hit = (brg_cnt == 8'h00);
    wire [1:0] pre_top = tx_stat[`ASP_TS_HIGH_SPEED] ? `ASP_PRE_FAST : `ASP_PRE_SLOW; // R24
    wire tick16 = brg_hit && (pre_cnt == pre_top); // R10
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn || !port_en)
        begin
            brg_cnt <= 8'h00;
            pre_cnt <= 2'h0;
        end
        else if (brg_hit)
        begin
            brg_cnt <= baud;
            pre_cnt <= (pre_cnt == pre_top) ? 2'h0 : pre_cnt + 2'h1;
        end
        else
            brg_cnt <= brg_cnt - 8'h01;
    end

    // receiver
    asp_rx_state_t rx_st;
    logic [3:0] ovs;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    // judge the stop bit at its middle, not at the edge where the last data bit may still stand
    wire rx_mid = tick16 && (ovs == `ASP_OVS_LAST); // R1
    wire rx_last_bit = rx_bits == (nine_rx ? 4'h8 : 4'h7); // R3
    wire rx_done = (rx_st == ASP_RX_STOP) && rx_mid;
    wire addr_ok = !(rx_stat[`ASP_RS_ADDR] && nine_rx) || rx_sh[8]; // R9 R25
    wire rx_deliver = rx_done && addr_ok;
    wire rx_framing_error = rx_done && !i_rx_pin; // R22
    wire rx_overrun = rx_deliver && rx_flag;
    wire rx_go = async_on && cont_en && !rx_stat[`ASP_RS_OVERRUN_ERROR]; // R3
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn || !rx_go)
        begin
            rx_st <= ASP_RX_IDLE;
            ovs <= 4'h0;
            rx_bits <= 4'h0;
            rx_sh <= 9'h000;
        end
        else if (tick16)
        begin
            ovs <= ovs + 4'h1;
            unique case (rx_st)
                ASP_RX_IDLE:
                begin
                    ovs <= 4'h0;
                    if (!i_rx_pin)
                        rx_st <= ASP_RX_START;
                end
                ASP_RX_START:
                    if (ovs == `ASP_OVS_MID)
                    begin
                        ovs <= 4'h0;
                        rx_st <= i_rx_pin ? ASP_RX_IDLE : ASP_RX_DATA;
                    end
                ASP_RX_DATA:
                    if (ovs == `ASP_OVS_LAST)
                    begin
                        rx_sh <= nine_rx ? {i_rx_pin, rx_sh[8:1]} : {1'b0, i_rx_pin, rx_sh[7:1]}; // R23
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_last_bit)
                            rx_st <= ASP_RX_STOP;
                    end
                ASP_RX_STOP:
                    if (ovs == `ASP_OVS_LAST)
                    begin
                        rx_st <= ASP_RX_IDLE;
                        rx_bits <= 4'h0;
                    end
            endcase
        end
    end

    // transmitter, sync master: clock idles low, data changes on falling clock edge
    asp_tx_state_t tx_st;
    logic [8:0] transmit_shift_register;
    logic [3:0] tx_bits;
    logic [3:0] tx_ovs;
    logic clk_line;
    logic tx_nine;
    wire tsr_empty = (tx_st == ASP_TX_IDLE);
    wire tx_load = tsr_empty && tx_buf_full && tx_en && master_on && (rx_st == ASP_RX_IDLE); // R14 R15
    wire tx_bit_end = tick16 && (tx_ovs == `ASP_OVS_LAST);
    wire tx_last = tx_bits == (tx_nine ? 4'h8 : 4'h7);
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn || !master_on || !tx_en)
        begin
            tx_st <= ASP_TX_IDLE;
            transmit_shift_register <= 9'h000;
            tx_bits <= 4'h0;
            tx_ovs <= 4'h0;
            clk_line <= 1'b0;
            tx_nine <= 1'b0;
        end
        else if (tx_load)
        begin
            transmit_shift_register <= {tx_stat[`ASP_TS_NINTH], tx_buf}; // R20
            tx_nine <= tx_stat[`ASP_TS_NINE];
            tx_st <= ASP_TX_DATA;
            tx_ovs <= 4'h0;
            tx_bits <= 4'h0;
        end
        else if ((tx_st == ASP_TX_DATA) && tick16)
        begin
            tx_ovs <= tx_ovs + 4'h1;
            clk_line <= (tx_ovs == `ASP_OVS_MID) ? 1'b1 : (tx_bit_end ? 1'b0 : clk_line); // R26
            if (tx_bit_end)
            begin
                transmit_shift_register <= {1'b0, transmit_shift_register[8:1]}; // R23
                tx_bits <= tx_bits + 4'h1;
                if (tx_last)
                    tx_st <= ASP_TX_IDLE; // R15
            end
        end
    end

    // registers
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            rx_stat <= 8'h00;
            tx_stat <= 8'h00;
            baud <= 8'h00;
            tx_buf <= 8'h00;
            tx_buf_full <= 1'b0;
            rx_buf <= 8'h00;
            rx_flag <= 1'b0;
            tx_flag <= 1'b0;
            enables <= 8'h00;
            prio <= 8'h00;
        end
        else
        begin
            if (wr_rs)
                rx_stat <= (i_wb.dat[7:0] & `ASP_RS_WR_MASK) | (rx_stat & ~`ASP_RS_WR_MASK);
            if (wr_ts)
                tx_stat <= (i_wb.dat[7:0] & `ASP_TS_WR_MASK) | (tx_stat & ~`ASP_TS_WR_MASK); // R19
            if (wr_baud)
                baud <= i_wb.dat[7:0];
            if (wr_en)
                enables <= i_wb.dat[7:0] & `ASP_PF_MASK; // R21
            if (wr_pr)
                prio <= i_wb.dat[7:0] & `ASP_PF_MASK;
            if (!cont_en || (wr_rs && !i_wb.dat[`ASP_RS_CONT]))
            begin
                rx_stat[`ASP_RS_FRAMING_ERROR] <= 1'b0; // R6
                rx_stat[`ASP_RS_OVERRUN_ERROR] <= 1'b0;
            end
            if (rx_overrun)
                rx_stat[`ASP_RS_OVERRUN_ERROR] <= 1'b1;
            else if (rx_deliver)
            begin
                rx_buf <= rx_sh[7:0]; // R5
                rx_stat[`ASP_RS_NINTH] <= rx_sh[8];
                rx_stat[`ASP_RS_FRAMING_ERROR] <= rx_framing_error;
            end
            // set wins over the clear made by reading the data
            if (rx_deliver && !rx_overrun)
                rx_flag <= 1'b1; // R4 R9
            else if (rd_rxd)
                rx_flag <= 1'b0;
            tx_stat[`ASP_TS_SHIFT_EMPTY] <= tsr_empty; // R19
            if (wr_txd)
            begin
                tx_buf <= i_wb.dat[7:0];
                tx_buf_full <= 1'b1;
            end
            else if (tx_load)
                tx_buf_full <= 1'b0; // R16
            // flag tracks buffer state and transmit enable; bus writes to the flag register are ignored
            tx_flag <= tx_en && !(wr_txd || (tx_buf_full && !tx_load)); // R16 R17
        end
    end

    wire [7:0] flags = {2'b00, rx_flag, tx_flag, 4'h0}; // R21
    always_comb
    begin
        unique case (i_wb.adr)
            `ASP_ADR_RX_STAT: rd_dat = {24'h0, rx_stat};
            `ASP_ADR_RX_DATA: rd_dat = {24'h0, rx_buf};
            `ASP_ADR_TX_STAT: rd_dat = {24'h0, tx_stat};
            `ASP_ADR_BAUD: rd_dat = {24'h0, baud};
            `ASP_ADR_TX_DATA: rd_dat = {24'h0, tx_buf};
            `ASP_ADR_FLAGS: rd_dat = {24'h0, flags};
            `ASP_ADR_ENABLES: rd_dat = {24'h0, enables};
            `ASP_ADR_PRIO: rd_dat = {24'h0, prio};
            default: rd_dat = 32'h0; // unmapped reads zero, still acked
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            ack <= 1'b0;
            rd_q <= 32'h0;
        end
        else
        begin
            ack <= bus_req;
            if (bus_rd)
                rd_q <= rd_dat;
        end
    end
    assign o_wb = '{dat: rd_q, ack: ack};

    assign o_rx_irq = rx_flag && enables[`ASP_PF_RX]; // R4
    assign o_tx_irq = tx_flag && enables[`ASP_PF_TX]; // R18
    assign o_tx_pin = master_on ? clk_line : 1'b1; // R13
    assign o_data_out = transmit_shift_register[0]; // R26
    assign o_data_oe = master_on && !tsr_empty; // R14
endmodule

// ### asp_serial_port_properties.sv
// bus, pin and interrupt relations of the serial port
`timescale 1ns/1ps
`include "asp_cfg.svh"
module asp_serial_port_properties
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire asp_pkg::asp_wb_req_t i_wb,
    input wire asp_pkg::asp_wb_rsp_t o_wb,
    input wire logic i_rx_pin,
    input wire logic o_tx_pin,
    input wire logic o_data_out,
    input wire logic o_data_oe,
    input wire logic o_rx_irq,
    input wire logic o_tx_irq
);
    import asp_pkg::*;
    logic [23:0] sh;
    logic [15:0] hi;
    // shadow follows the edge at which the port takes the write, not the ack edge
    wire wr = i_wb.cyc && i_wb.stb && !o_wb.ack && i_wb.we && i_wb.sel[0];
    wire rd = o_wb.ack && !i_wb.we;
    // shift clock high time is eight ticks of the baud generator
    wire [15:0] hi_exp = (16'(sh[23:16]) + 16'h1) << (sh[2] ? 3 : 5);
    // shadow of baud, enables and transmit status, kept from the bus
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
            sh <= 24'h0;
        else if (wr && i_wb.adr == `ASP_ADR_TX_STAT)
            sh[7:0] <= i_wb.dat[7:0];
        else if (wr && i_wb.adr == `ASP_ADR_ENABLES)
            sh[15:8] <= i_wb.dat[7:0];
        else if (wr && i_wb.adr == `ASP_ADR_BAUD)
            sh[23:16] <= i_wb.dat[7:0];
    end
    always_ff @(posedge i_clk_sys)
        hi <= o_tx_pin ? hi + 16'h1 : 16'h0;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    property p_ack_next;
        i_wb.cyc && i_wb.stb && !o_wb.ack |=> o_wb.ack ##1 !o_wb.ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus answer late or long");
    property p_async_idle;
        !sh[4] [*2] |-> o_tx_pin && !o_data_oe;
    endproperty
    a_async_idle: assert property (p_async_idle) else $error("pins active in async mode");
    property p_clk_gate;
        sh[4] && $past(sh[4]) && o_tx_pin |-> o_data_oe;
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("shift clock outside a word");
    property p_data_hold;
        o_data_oe && o_tx_pin && $past(o_tx_pin) |-> $stable(o_data_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
    property p_clk_high;
        $fell(o_tx_pin) && $past(o_data_oe) && sh[4] |-> hi == hi_exp;
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("shift clock high time wrong");
    property p_rx_irq;
        o_rx_irq |-> sh[13] || $past(sh[13]);
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("receive request while masked");
    property p_tx_irq;
        o_tx_irq |-> sh[12] || $past(sh[12]);
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("transmit request while masked");
    property p_zero_bits;
        rd && (i_wb.adr == `ASP_ADR_FLAGS || i_wb.adr == `ASP_ADR_ENABLES) |-> (o_wb.dat & 32'hffffffcf) == 32'h0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("unused flag bits not zero");
    c_rx_word: cover property (o_rx_irq);
    c_sync_bit: cover property ($fell(o_tx_pin) && o_data_oe);
    c_tx_empty: cover property (o_tx_irq);
endmodule
bind asp_serial_port asp_serial_port_properties u_props
(
    .i_clk_sys, .i_resetn, .i_wb, .o_wb, .i_rx_pin,
    .o_tx_pin, .o_data_out, .o_data_oe, .o_rx_irq, .o_tx_irq
);

// ### asp_serial_port_tb.sv
// self-checking bench of the addressable serial port
`timescale 1ns/1ps
`include "asp_cfg.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h seen %h", nm, e, g); end end
module asp_serial_port_tb;
    import asp_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    asp_wb_req_t req = '0;
    asp_wb_rsp_t rsp;
    logic rx_line;
    logic sck;
    logic sdo;
    logic oe;
    logic rx_irq;
    logic tx_irq;
    logic [31:0] q;
    int num_errors = 0;
    int checks = 0;
    always #25 i_clk_sys = ~i_clk_sys;
    asp_serial_port u_dut
    (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wb(req), .o_wb(rsp),
        .i_rx_pin(rx_line), .o_tx_pin(sck), .o_data_out(sdo), .o_data_oe(oe),
        .o_rx_irq(rx_irq), .o_tx_irq(tx_irq)
    );
    asp_remote_node u_node
    (
        .i_clk_sys(i_clk_sys), .i_sck(sck), .i_sdo(sdo), .i_oe(oe), .o_line(rx_line)
    );
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tmo(input int k);
        if (k >= 2000)
        begin
            num_errors++;
            give_verdict();
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        int k;
        k = 0;
        req <= '{adr: a, dat: {24'h0, d}, we: w, sel: 4'h1, cyc: 1'b1, stb: 1'b1};
        @(posedge i_clk_sys);
        while (rsp.ack !== 1'b1 && k < 2000)
        begin
            k++;
            @(posedge i_clk_sys);
        end
        tmo(k);
        q = rsp.dat;
        req <= '0;
        @(posedge i_clk_sys);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 8'h0);
        `CHK(nm, e, q)
    endtask
    task automatic t_reset_regs();
        for (int a = 0; a < 9; a++)
            rd(6'(a * 4), (a == 2) ? 32'h2 : 32'h0, "reset value");
    endtask
    task automatic t_async_rx();
        wb(1'b1, `ASP_ADR_TX_STAT, 8'h04);
        wb(1'b1, `ASP_ADR_ENABLES, 8'h20);
        wb(1'b1, `ASP_ADR_RX_STAT, 8'h80);
        u_node.send(9'h04b, 8, 1'b1, 16);
        `CHK("rx irq idle", 1'b0, rx_irq)
        wb(1'b1, `ASP_ADR_RX_STAT, 8'h90);
        u_node.send(9'h04b, 8, 1'b1, 16);
        `CHK("rx irq", 1'b1, rx_irq)
        rd(`ASP_ADR_RX_DATA, 32'h4b, "rx data");
        `CHK("rx irq cleared", 1'b0, rx_irq)
        wb(1'b1, `ASP_ADR_ENABLES, 8'h00);
        wb(1'b1, `ASP_ADR_TX_STAT, 8'h00);
        u_node.send(9'h0e1, 8, 1'b1, 64);
        `CHK("rx irq masked", 1'b0, rx_irq)
        rd(`ASP_ADR_FLAGS, 32'h20, "rx flag");
        rd(`ASP_ADR_RX_DATA, 32'he1, "slow data");
    endtask
    task automatic t_nine_addr();
        wb(1'b1, `ASP_ADR_ENABLES, 8'h20);
        wb(1'b1, `ASP_ADR_TX_STAT, 8'h04);
        wb(1'b1, `ASP_ADR_RX_STAT, 8'hc8);
        wb(1'b1, `ASP_ADR_RX_STAT, 8'hd8);
        u_node.send(9'h033, 9, 1'b1, 16);
        `CHK("data word dropped", 1'b0, rx_irq)
        u_node.send(9'h1a6, 9, 1'b1, 16);
        `CHK("address word", 1'b1, rx_irq)
        rd(`ASP_ADR_RX_STAT, 32'hd9, "ninth set");
        rd(`ASP_ADR_RX_DATA, 32'ha6, "address");
        wb(1'b1, `ASP_ADR_RX_STAT, 8'hd0);
        u_node.send(9'h033, 9, 1'b1, 16);
        `CHK("every word", 1'b1, rx_irq)
        rd(`ASP_ADR_RX_STAT, 32'hd0, "ninth clear");
        rd(`ASP_ADR_RX_DATA, 32'h33, "data word");
    endtask
    task automatic t_errors();
        u_node.send(9'h055, 9, 1'b0, 16);
        rd(`ASP_ADR_RX_STAT, 32'hd4, "framing");
        rd(`ASP_ADR_RX_DATA, 32'h55, "framed data");
        wb(1'b1, `ASP_ADR_RX_STAT, 8'hc0);
        rd(`ASP_ADR_RX_STAT, 32'hc0, "errors cleared");
    endtask
    task automatic t_sync_tx();
        int k;
        k = 0;
        wb(1'b1, `ASP_ADR_RX_STAT, 8'h80);
        wb(1'b1, `ASP_ADR_ENABLES, 8'h10);
        wb(1'b1, `ASP_ADR_TX_STAT, 8'hb4);
        `CHK("tx empty", 1'b1, tx_irq)
        wb(1'b1, `ASP_ADR_TX_DATA, 8'h4b);
        wb(1'b1, `ASP_ADR_TX_DATA, 8'hc3);
        `CHK("buffer full", 1'b0, tx_irq)
        rd(`ASP_ADR_TX_STAT, 32'hb4, "shifter busy");
        while ((u_node.n < 16 || oe !== 1'b0) && k < 2000)
        begin
            k++;
            @(posedge i_clk_sys);
        end
        tmo(k);
        `CHK("bit count", 16, u_node.n)
        `CHK("words", 16'hc34b, u_node.got)
        wb(1'b1, `ASP_ADR_FLAGS, 8'h00);
        rd(`ASP_ADR_FLAGS, 32'h10, "empty flag held");
        rd(`ASP_ADR_TX_STAT, 32'hb6, "shifter empty");
    endtask
    initial
    begin
        repeat (5) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        @(posedge i_clk_sys);
        t_reset_regs();
        t_async_rx();
        t_nine_addr();
        t_errors();
        t_sync_tx();
        give_verdict();
    end
endmodule
